// ==== core/ssf_pkg.sv ====
// Purpose: shared constants and types of the serial memory front end
// Assumes: 8-bit words, 13-bit word pointer
// Notes: mode field layout and codes are local choices
package ssf_pkg;
   localparam int CMD_W = 8;
   localparam int ADDR_W = 16;
   localparam int PTR_W = 13;
   localparam int DATA_W = 8;
   localparam int PAGE_W = 5;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CMD_LAST = 5'h07;
   localparam logic [CNT_W-1:0] ADDR_LAST = 5'h0f;
   localparam logic [CNT_W-1:0] DATA_LAST = 5'h07;
   localparam logic [CNT_W-1:0] RW_HDR_BITS = 5'h18;
   localparam logic [CNT_W-1:0] MODE_HDR_BITS = 5'h08;
   localparam logic [7:0] CMD_READ = 8'h03;
   localparam logic [7:0] CMD_WRITE = 8'h02;
   localparam logic [7:0] MODE_REG_READ_CMD = 8'h05;
   localparam logic [7:0] MODE_REG_WRITE_CMD = 8'h01;
   localparam int MODE_HI = 7;
   localparam int MODE_LO = 6;
   localparam logic [1:0] MODE_WORD = 2'h0;
   localparam logic [1:0] MODE_BURST = 2'h1;
   localparam logic [1:0] MODE_PAGE = 2'h2;
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] MODE_RD_SET = 8'h02;
   typedef enum logic [3:0] {
      DS_CMD = 4'h1, DS_ADDR = 4'h2, DS_DATA = 4'h4, DS_SKIP = 4'h8
   } ssf_dev_state_type;
   typedef enum logic [3:0] {
      HS_IDLE = 4'h1, HS_WAKE = 4'h2, HS_RUN = 4'h4, HS_END = 4'h8
   } ssf_host_state_type;

   // next word pointer for page, burst or single word access
   function automatic logic [PTR_W-1:0] ssf_next_ptr(input logic [PTR_W-1:0] p,
                                                      input logic [1:0] m);
      logic [PTR_W-1:0] r;
      r = p;
      if (m == MODE_PAGE) begin
         r[PAGE_W-1:0] = p[PAGE_W-1:0] + 5'h01; // R20
      end else if (m == MODE_BURST) begin
         r = p + 13'h0001; // R21
      end
      return r;
   endfunction : ssf_next_ptr
endpackage : ssf_pkg

// ==== core/ssf_link_if.sv ====
// Purpose: serial link between host and memory front end
// Assumes: host samples so directly; so_oe only feeds the link checker
// Notes: cs_n and hold_n are active low
`timescale 1ns/1ns
`default_nettype none
interface ssf_link_if;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   logic hold_n;
   modport device (input cs_n, input sck, input si, input hold_n, output so, output so_oe);
   modport host (output cs_n, output sck, output si, output hold_n, input so, input so_oe);
endinterface : ssf_link_if
`default_nettype wire

// ==== core/ssf_device.sv ====
// Purpose: device end, serial command decoder with 8k x 8 array
// Assumes: link logic runs on the serial clock, deselect clears sequence
// Notes: mode register is published to the system clock by toggle handshake
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R1] select low runs, select high standby
// [R2] deselect lets write cycle finish first
// [R3] output floats while deselected
// [R4] host selects once after power-up
// [R5] input bits captured on rising clock
// [R6] output changes only after falling clock
// [R7] pause low suspends, sequence state kept
// [R8] pause starts now if clock low
// [R9] host keeps select low while paused
// [R10] paused: output floats, inputs ignored
// [R11] resume with clock low, continue exactly
// [R12] pause low always floats output
// [R13] eight-bit instruction register from input
// [R14] host holds select and pause steady
// [R15] first bit on first rise after select
// [R16] all fields shifted msb first
// [R17] decode memory read and write codes
// [R18] decode mode register read and write
// [R19] sixteen-bit address, top three ignored
// [R20] page mode wraps within 32 words
// [R21] burst mode wraps 1fff to 0000
// [R22] burst and page array transfers end only on deselect, others after one byte
// [R23] thirteen-bit word pointer spans array
module ssf_device
   import ssf_pkg::*;
#(
   parameter int MEM_WORDS = 8192
) (
   // system side
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // link
   ssf_link_if.device link,
   // user side
   output logic [DATA_W-1:0] mode_o,
   output logic mode_upd_o,
   output logic selected_o
);
   ////////////////////////////////////////////////////////////////////////////////
   ssf_dev_state_type state;
   logic [CNT_W-1:0] bit_cnt;
   logic [DATA_W-1:0] rx_sr;
   logic [CMD_W-1:0] cmd;
   logic [PTR_W-1:0] ptr;
   logic [DATA_W-1:0] tx_sr;
   logic [DATA_W-1:0] mode;
   logic mode_tgl;
   logic so_q;
   logic tx_on;
   logic [DATA_W-1:0] mem [MEM_WORDS];
   logic [DATA_W-1:0] next_rx;
   logic [PTR_W-1:0] next_ptr;
   logic [PTR_W-1:0] next_addr;
   logic byte_end;
   logic is_read;
   logic mem_wr;
   logic mode_wr;
   logic tgl_s1;
   logic tgl_s2;
   logic tgl_s3;
   logic cs_s1;
   logic cs_s2;

   assign next_rx = {rx_sr[DATA_W-2:0], link.si}; // R16
   assign next_addr = {ptr[PTR_W-2:0], link.si}; // R19 R23
   assign next_ptr = ssf_next_ptr(ptr, mode[MODE_HI:MODE_LO]);
   assign byte_end = (state == DS_DATA) && (bit_cnt == DATA_LAST);
   assign is_read = (cmd == CMD_READ) || (cmd == MODE_REG_READ_CMD);
   assign mem_wr = !link.cs_n && link.hold_n && byte_end && (cmd == CMD_WRITE);
   assign mode_wr = !link.cs_n && link.hold_n && byte_end && (cmd == MODE_REG_WRITE_CMD);

   ////////////////////////////////////////////////////////////////////////////////
   // command sequencer, rising serial clock
   always_ff @(posedge link.sck or posedge link.cs_n) begin
      if (link.cs_n) begin // R1 R22
         state <= DS_CMD; // R15
         bit_cnt <= '0;
         rx_sr <= '0;
         cmd <= '0;
         ptr <= '0;
         tx_sr <= '0;
      end else if (link.hold_n) begin // R7 R10 R11
         rx_sr <= next_rx; // R5
         bit_cnt <= bit_cnt + 5'h01;
         case (state)
            DS_CMD: begin
               if (bit_cnt == CMD_LAST) begin
                  cmd <= next_rx; // R13
                  bit_cnt <= '0;
                  if (next_rx == CMD_READ || next_rx == CMD_WRITE) begin // R17
                     state <= DS_ADDR;
                  end else if (next_rx == MODE_REG_READ_CMD) begin // R18
                     state <= DS_DATA;
                     tx_sr <= mode | MODE_RD_SET;
                  end else if (next_rx == MODE_REG_WRITE_CMD) begin // R18
                     state <= DS_DATA;
                  end else begin
                     state <= DS_SKIP;
                  end
               end
            end
            DS_ADDR: begin
               ptr <= next_addr; // R19
               if (bit_cnt == ADDR_LAST) begin
                  state <= DS_DATA;
                  bit_cnt <= '0;
                  tx_sr <= mem[next_addr]; // R17
               end
            end
            DS_DATA: begin
               if (bit_cnt == DATA_LAST) begin
                  bit_cnt <= '0;
                  ptr <= next_ptr; // R20 R21
                  tx_sr <= mem[next_ptr];
                  if (cmd == MODE_REG_READ_CMD || cmd == MODE_REG_WRITE_CMD ||
                      mode[MODE_HI:MODE_LO] == MODE_WORD ||
                      mode[MODE_HI:MODE_LO] == 2'h3) begin
                     state <= DS_SKIP;
                  end
               end else begin
                  tx_sr <= {tx_sr[DATA_W-2:0], 1'b0}; // R16
               end
            end
            DS_SKIP: begin
               bit_cnt <= '0;
            end
            default: begin
               state <= DS_SKIP;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // array write completes on the edge of the last data bit
   always_ff @(posedge link.sck) begin
      if (mem_wr) begin // R2
         mem[ptr] <= next_rx;
      end
   end

   // mode register survives deselect
   always_ff @(posedge link.sck or posedge rst_i) begin
      if (rst_i) begin
         mode <= MODE_RST;
         mode_tgl <= 1'b0;
      end else if (mode_wr) begin // R18
         mode <= next_rx;
         mode_tgl <= ~mode_tgl;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output stage, falling serial clock
   always_ff @(negedge link.sck or posedge link.cs_n) begin
      if (link.cs_n) begin
         so_q <= 1'b0;
         tx_on <= 1'b0;
      end else if (link.hold_n) begin // R8
         so_q <= tx_sr[DATA_W-1]; // R6
         tx_on <= (state == DS_DATA) && is_read;
      end
   end

   assign link.so = so_q;
   assign link.so_oe = !link.cs_n && link.hold_n && tx_on; // R3 R10 R12

   ////////////////////////////////////////////////////////////////////////////////
   // system clock side
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         tgl_s1 <= 1'b0;
         tgl_s2 <= 1'b0;
         tgl_s3 <= 1'b0;
         cs_s1 <= 1'b1;
         cs_s2 <= 1'b1;
      end else begin
         tgl_s1 <= mode_tgl;
         tgl_s2 <= tgl_s1;
         tgl_s3 <= tgl_s2;
         cs_s1 <= link.cs_n;
         cs_s2 <= cs_s1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         mode_o <= MODE_RST;
         mode_upd_o <= 1'b0;
         selected_o <= 1'b0;
      end else begin
         mode_upd_o <= tgl_s2 ^ tgl_s3;
         if (tgl_s2 ^ tgl_s3) begin
            mode_o <= mode;
         end
         selected_o <= !cs_s2;
      end
   end
endmodule : ssf_device
`default_nettype wire

// ==== core/ssf_host.sv ====
// Purpose: host end, drives select, serial clock, input and pause
// Assumes: HALF_CYC of at least 2 so the synced output is sampled in time
// Notes: serial clock is a divided system clock
`timescale 1ns/1ns
`default_nettype none
module ssf_host
   import ssf_pkg::*;
#(
   parameter int HALF_CYC = 2,
   parameter int WORDS_W = 8
) (
   // system side
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // link
   ssf_link_if.host link,
   // request
   input wire logic start_i,
   input wire logic [CMD_W-1:0] cmd_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [WORDS_W-1:0] words_i,
   input wire logic [DATA_W-1:0] wdata_i,
   input wire logic pause_i,
   // answer
   output logic busy_o,
   output logic wdata_take_o,
   output logic [DATA_W-1:0] rdata_o,
   output logic rdata_valid_o,
   output logic done_o
);
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] DIV_LAST = 8'(HALF_CYC - 1);
   ssf_host_state_type state;
   logic [7:0] div;
   logic sck_q;
   logic cs_n_q;
   logic hold_n_q;
   logic [31:0] out_sr;
   logic [31:0] next_out;
   logic [CNT_W-1:0] hdr_left;
   logic [2:0] dbit;
   logic [WORDS_W-1:0] words_left;
   logic rd_cmd;
   logic op;
   logic [DATA_W-1:0] rx_sr;
   logic so_s1;
   logic so_s2;
   logic rw;

   assign rw = (cmd_i == CMD_READ) || (cmd_i == CMD_WRITE);
   assign busy_o = (state != HS_IDLE);
   assign link.sck = sck_q;
   assign link.cs_n = cs_n_q;
   assign link.hold_n = hold_n_q;
   assign link.si = out_sr[31]; // R16
   assign next_out = {out_sr[30:0], 1'b0};

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         so_s1 <= 1'b0;
         so_s2 <= 1'b0;
      end else begin
         so_s1 <= link.so;
         so_s2 <= so_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         state <= HS_WAKE;
         div <= '0;
         sck_q <= 1'b0;
         cs_n_q <= 1'b1;
         hold_n_q <= 1'b1;
         out_sr <= '0;
         hdr_left <= '0;
         dbit <= '0;
         words_left <= '0;
         rd_cmd <= 1'b0;
         op <= 1'b0;
         rx_sr <= '0;
         rdata_o <= '0;
         rdata_valid_o <= 1'b0;
         wdata_take_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         rdata_valid_o <= 1'b0;
         wdata_take_o <= 1'b0;
         done_o <= 1'b0;
         case (state)
            HS_WAKE: begin
               cs_n_q <= 1'b0; // R4
               op <= 1'b0;
               div <= '0;
               state <= HS_END;
            end
            HS_IDLE: begin
               if (start_i) begin
                  cs_n_q <= 1'b0;
                  sck_q <= 1'b0;
                  div <= '0;
                  op <= 1'b1;
                  dbit <= '0;
                  words_left <= (words_i == '0) ? WORDS_W'(1) : words_i;
                  rd_cmd <= (cmd_i == CMD_READ) || (cmd_i == MODE_REG_READ_CMD);
                  wdata_take_o <= 1'b1;
                  if (rw) begin
                     out_sr <= {cmd_i, addr_i, wdata_i};
                     hdr_left <= RW_HDR_BITS;
                  end else begin
                     out_sr <= {cmd_i, wdata_i, 16'h0000};
                     hdr_left <= MODE_HDR_BITS;
                  end
                  state <= HS_RUN;
               end
            end
            HS_RUN: begin
               if (!sck_q && (pause_i || !hold_n_q)) begin // R9 R11
                  hold_n_q <= !pause_i;
                  div <= '0;
               end else if (div != DIV_LAST) begin
                  div <= div + 8'h01;
               end else begin
                  div <= '0;
                  sck_q <= !sck_q;
                  if (sck_q) begin
                     out_sr <= next_out;
                     if (hdr_left != '0) begin
                        hdr_left <= hdr_left - 5'h01;
                     end else begin
                        dbit <= dbit + 3'h1;
                        rx_sr <= {rx_sr[DATA_W-2:0], so_s2};
                        if (dbit == 3'h7) begin
                           rdata_o <= {rx_sr[DATA_W-2:0], so_s2};
                           rdata_valid_o <= rd_cmd;
                           words_left <= words_left - WORDS_W'(1);
                           if (words_left == WORDS_W'(1)) begin
                              state <= HS_END; // R22
                              done_o <= 1'b1;
                           end else begin
                              out_sr <= {wdata_i, next_out[23:0]};
                              wdata_take_o <= 1'b1;
                           end
                        end
                     end
                  end
               end
            end
            HS_END: begin
               cs_n_q <= 1'b1; // R14
               sck_q <= 1'b0;
               hold_n_q <= 1'b1;
               if (div != DIV_LAST) begin
                  div <= div + 8'h01;
               end else begin
                  div <= '0;
                  state <= HS_IDLE;
               end
            end
            default: begin
               state <= HS_END;
            end
         endcase
      end
   end
endmodule : ssf_host
`default_nettype wire

// ==== verif/ssf_link_chk.sv ====
// Purpose: concurrent checks on the serial link between host and device
// Assumes: all link signals move on system clock edges or just after them
// Notes: sampled on the system clock, so edges of sck show as $rose/$fell
`timescale 1ns/1ns
`default_nettype none
module ssf_link_chk (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic rst_i,
   // link
   input wire logic cs_n,
   input wire logic sck,
   input wire logic si,
   input wire logic so,
   input wire logic so_oe,
   input wire logic hold_n
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   ////////////////////////////////////////////////////////////////////////////
   a_oe_desel: assert property (cs_n |-> !so_oe)
      else $error("output driven while deselected");
   a_oe_pause: assert property (!hold_n |-> !so_oe)
      else $error("output driven while paused");
   a_so_fall: assert property (!cs_n && $past(!cs_n) && $changed(so) |-> $fell(sck))
      else $error("output moved without falling clock");
   a_so_hold: assert property (!hold_n |-> $stable(so))
      else $error("output moved during pause");
   a_cs_pause: assert property (!hold_n |-> !cs_n)
      else $error("deselected during pause");
   a_pause_low: assert property ($fell(hold_n) |-> !sck)
      else $error("pause raised with clock high");
   a_resume_low: assert property ($rose(hold_n) |-> !sck && !cs_n)
      else $error("resume with clock high");
   a_wake_sel: assert property ($fell(rst_i) |-> ##[0:4] !cs_n)
      else $error("no select after reset");
   ////////////////////////////////////////////////////////////////////////////
   c_pause: cover property ($fell(hold_n));
   c_frame_end: cover property ($rose(cs_n));
   c_data_one: cover property (!cs_n && hold_n && $rose(sck) && si);
   c_drive: cover property (so_oe);
endmodule : ssf_link_chk
`default_nettype wire

// ==== verif/serial_sram_spi_front_end_tb.sv ====
// Purpose: host and device joined on one link, checked against an associative array model
// Assumes: host divides the system clock for sck, HALF_CYC of 2
// Notes: word mode compares only the first byte of a read
`timescale 1ns/1ns
`default_nettype none
module serial_sram_spi_front_end_tb;
   import ssf_pkg::*;
   logic clk_sys_i = 0;
   logic rst_i = 0;
   logic start_i = 0;
   logic pause_i = 0;
   logic [CMD_W-1:0] cmd_i = '0;
   logic [ADDR_W-1:0] addr_i = '0;
   logic [7:0] words_i = '0;
   logic [DATA_W-1:0] wdata_i = '0;
   logic busy_o, wdata_take_o, rdata_valid_o, done_o, mode_upd_o, selected_o;
   logic [DATA_W-1:0] rdata_o, mode_o;
   int mismatches = 0;
   int n_tests = 0;
   int mem [int];
   int md = 0;
   int rises = 0;
   int upd_cnt = 0;
   int upd_exp = 0;
   logic [7:0] first_cmd = '0;
   logic [7:0] wq [$];
   logic [7:0] rq [$];
   logic [7:0] mt [4] = '{8'h40, 8'h80, 8'h00, 8'hc0};
   logic [15:0] a;

   always #50 clk_sys_i = ~clk_sys_i;
   ssf_link_if link_if ();
   ssf_host #(.HALF_CYC(2), .WORDS_W(8)) ssf_host_i (.clk_sys_i, .rst_i, .link(link_if.host),
      .start_i, .cmd_i, .addr_i, .words_i, .wdata_i, .pause_i, .busy_o, .wdata_take_o,
      .rdata_o, .rdata_valid_o, .done_o);
   ssf_device ssf_device_i (.clk_sys_i, .rst_i, .link(link_if.device), .mode_o, .mode_upd_o,
      .selected_o);
   ssf_link_chk ssf_link_chk_i (.clk_sys_i, .rst_i, .cs_n(link_if.cs_n), .sck(link_if.sck),
      .si(link_if.si), .so(link_if.so), .so_oe(link_if.so_oe), .hold_n(link_if.hold_n));
   ////////////////////////////////////////////////////////////////////////////
   // wire monitor: count clock rises of a frame and catch the first byte
   always @(negedge link_if.cs_n) rises = 0;
   always @(posedge link_if.sck) begin
      if (!link_if.cs_n && link_if.hold_n) begin
         if (rises < 8) first_cmd = {first_cmd[6:0], link_if.si};
         rises++;
      end
   end
   always @(posedge clk_sys_i) if (mode_upd_o === 1'b1) upd_cnt++;
   ////////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task test_done;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done

   function int nxt(int p);
      if (md == 2) return (p & 32'h1fe0) | ((p + 1) & 32'h001f);
      if (md == 1) return (p + 1) & 32'h1fff;
      return p;
   endfunction : nxt

   // one host request; p is the loop step where a pause begins, 0 for none
   task run(input logic [7:0] c, input logic [15:0] ad, input int n, input int p, input int hdr);
      int k;
      int i;
      logic adv;
      logic sel;
      k = 0;
      i = 0;
      adv = 0;
      sel = 0;
      rq = {};
      while (busy_o !== 1'b0 && i < 100) begin
         @(negedge clk_sys_i);
         i++;
      end
      cmd_i = c;
      addr_i = ad;
      words_i = n[7:0];
      wdata_i = (wq.size() > 0) ? wq[0] : 8'h00;
      start_i = 1;
      i = 0;
      do begin
         @(negedge clk_sys_i);
         start_i = 0;
         i++;
         if (adv && k + 1 < wq.size()) begin
            k++;
            wdata_i = wq[k];
         end
         adv = (wdata_take_o === 1'b1);
         pause_i = (p > 0 && i >= p && i < p + 12);
         if (rdata_valid_o === 1'b1) rq.push_back(rdata_o);
         if (selected_o === 1'b1) sel = 1;
      end while (done_o !== 1'b1 && i < 3000);
      pause_i = 0;
      check(done_o, 1'b1);
      check(busy_o, 1'b1);
      check(first_cmd, c);
      if (hdr >= 0) check(rises, hdr + 8 * n);
      repeat (6) @(negedge clk_sys_i);
      check(selected_o, 1'b0);
      check(busy_o, 1'b0);
      check(sel, 1'b1);
   endtask : run

   task rd(input logic [15:0] ad, input int n, input int p);
      int q;
      run(CMD_READ, ad, n, p, 24);
      check(rq.size(), n);
      q = ad & 32'h1fff;
      for (int i = 0; i < n && i < rq.size(); i++) begin
         if (i == 0 || md == 1 || md == 2) check(rq[i], mem[q]);
         q = nxt(q);
      end
   endtask : rd

   task wr(input logic [15:0] ad, input int n, input int p);
      int q;
      wq = {};
      for (int i = 0; i < n; i++) wq.push_back(8'($urandom));
      run(CMD_WRITE, ad, n, p, 24);
      q = ad & 32'h1fff;
      for (int i = 0; i < n; i++) begin
         if (i == 0 || md == 1 || md == 2) mem[q] = wq[i];
         q = nxt(q);
      end
   endtask : wr
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #2_000_000;
      mismatches++;
      test_done;
   end

   initial begin
      void'($urandom(61035));
      // raise reset after time zero so the serial side mode register sees its edge
      #1 rst_i = 1;
      repeat (2) @(negedge clk_sys_i);
      rst_i = 0;
      check(mode_o, MODE_RST);
      foreach (mt[j]) begin
         wq = {mt[j]};
         run(MODE_REG_WRITE_CMD, 16'h0000, 1, 0, 8);
         md = mt[j][7:6];
         upd_exp++;
         repeat (10) @(negedge clk_sys_i);
         check(mode_o, mt[j]);
         check(upd_cnt, upd_exp);
         run(MODE_REG_READ_CMD, 16'h0000, 1, 0, 8);
         check(rq.size() > 0 ? rq[0] : 8'hxx, mt[j] | MODE_RD_SET);
         a = 16'($urandom);
         if (md == 1) a[12:0] = 13'h1ffe;
         if (md == 2) a[4:0] = 5'h1e;
         wr(a, 4, 37);
         // pause lands in the data phase; the output is driven then only in burst and page modes
         rd(a, 4, 110 + 9 * j);
         $display("test mode %h done", mt[j]);
      end
      // an undefined code must leave the array alone
      wq = {8'h5a};
      run(8'h07, a, 1, 0, -1);
      rd(a, 1, 0);
      $display("test undefined code done");
      test_done;
   end
endmodule : serial_sram_spi_front_end_tb
`default_nettype wire
